// file: shared/pwm_shutdown_pkg.sv
// register map, field layout and encodings of the pwm auto-shutdown block
// assumes an 8-bit register port with a two-bit word address
package pwm_shutdown_pkg;

  // ==========================================================
  // register port
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] ADDR_SHUTDOWN = 2'h0;
  localparam logic [1:0] ADDR_RESTART = 2'h1;
  localparam logic [1:0] ADDR_PWM_CTRL = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // ==========================================================
  // shutdown_control fields
  localparam int SD_FLAG_BIT = 7;
  localparam int SD_SRC_LSB = 4;
  localparam int SD_AC_LSB = 2;
  localparam int SD_BD_LSB = 0;
  localparam int SRC_W = 3;
  localparam int PSS_W = 2;
  localparam int PSS_LEVEL_BIT = 0;
  localparam int PSS_TRI_BIT = 1;
  localparam logic [7:0] SHUTDOWN_RST = 8'h00;

  // ==========================================================
  // restart_and_deadband fields
  localparam int RS_EN_BIT = 7;
  localparam int DB_MAX_W = 7;
  localparam logic [7:0] RESTART_RST = 8'h00;

  // ==========================================================
  // pwm_control fields and status fields
  localparam int PC_CFG_LSB = 6;
  localparam int PC_POL_AC_BIT = 1;
  localparam int PC_POL_BD_BIT = 0;
  localparam logic [7:0] PWM_CTRL_RST = 8'h00;
  localparam int ST_FORCED_BIT = 0;
  localparam int ST_CAUSE_BIT = 1;

  // ==========================================================
  // output configurations
  typedef enum logic [1:0] {
    CFG_SINGLE = 2'h0,
    CFG_FULL_FWD = 2'h1,
    CFG_HALF = 2'h2,
    CFG_FULL_REV = 2'h3
  } out_cfg_t;

endpackage : pwm_shutdown_pkg

// file: shared/deadband_if.sv
// carries one pwm phase into a dead-band delay stage and back
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none

interface deadband_if #(parameter int W = 7);
  logic raw;
  logic [W-1:0] count;
  logic shaped;

  modport ctrl (output raw, output count, input shaped);
  modport delay (input raw, input count, output shaped);
endinterface : deadband_if

`default_nettype wire

// file: hw/deadband_delay.sv
// delays the rising edge of one pwm phase by a programmed cycle count
// assumes raw and count come from logic on clk
`timescale 1ns/1ps
`default_nettype none

module deadband_delay #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic reset_n,
  deadband_if.delay link
);

  // ==========================================================
  // delay counter
  logic [W-1:0] cnt_q;
  logic out_q;

  // falling edge passes after one cycle, rising after count + 1
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (!link.raw) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (!out_q) begin
      if (cnt_q == link.count) begin
        out_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign link.shaped = out_q;

endmodule : deadband_delay

`default_nettype wire

// file: hw/pwm_auto_shutdown.sv
// pwm output stage with auto-shutdown, restart and dead-band delay
// assumes clk is the instruction clock; pwm_raw and period_start come
// from the period/duty generator on clk; comparators and fault pin
// are asynchronous
//
// Contract
// - shutdown acts only in enhanced output configurations, on used pins
// - three-bit source select picks comparators and fault pin, 000 off
// - a selected event forces the pins at once, without a clock
// - a/c pair shutdown state: 00 low, 01 high, 1x released
// - b/d pair shutdown state: 00 low, 01 high, 1x released
// - status flag bit 7 is set by hardware on a shutdown event
// - flag set at period start keeps shutdown for the whole period
// - after the flag clears, outputs resume only at next period start
// - writes to the flag are ignored while a cause is active
// - with restart enabled the flag clears itself when the cause ends
// - with restart disabled the flag holds until software clears it
// - an active comparator cause keeps the flag from clearing
// - writing 1 to the flag forces shutdown like a hardware event
// - seven-bit count delays each half-bridge inactive-to-active edge in cycles
// - separate active-low select for the a/c and b/d pairs
// - half-bridge delay only on inactive-to-active transitions
// - half-bridge drives pwm on out_a and its complement on out_b
`timescale 1ns/1ps
`default_nettype none

module pwm_auto_shutdown #(
  parameter int DB_W = 7
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic pwm_raw,
  input wire logic period_start,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic fault_input,
  output logic out_a,
  output logic out_a_oe,
  output logic out_b,
  output logic out_b_oe,
  output logic out_c,
  output logic out_c_oe,
  output logic out_d,
  output logic out_d_oe
);

  // ==========================================================
  // elaboration check
  if (DB_W < 1 || DB_W > pwm_shutdown_pkg::DB_MAX_W) begin : g_bad_w
    $error("dead-band width must be 1 to 7");
  end

  // ==========================================================
  // register decode
  wire wr_sd = reg_wr && (reg_addr == pwm_shutdown_pkg::ADDR_SHUTDOWN);
  wire wr_rs = reg_wr && (reg_addr == pwm_shutdown_pkg::ADDR_RESTART);
  wire wr_pc = reg_wr && (reg_addr == pwm_shutdown_pkg::ADDR_PWM_CTRL);

  logic flag_q;
  logic flag_d;
  logic [pwm_shutdown_pkg::SRC_W-1:0] src_q;
  logic [pwm_shutdown_pkg::PSS_W-1:0] ac_state_q;
  logic [pwm_shutdown_pkg::PSS_W-1:0] bd_state_q;
  logic restart_en_q;
  logic [DB_W-1:0] db_count_q;
  pwm_shutdown_pkg::out_cfg_t cfg_q;
  pwm_shutdown_pkg::out_cfg_t cfg_act_q;
  logic pol_ac_q;
  logic pol_bd_q;
  logic hold_q;
  logic hold_d;
  logic [7:0] rdata_q;

  // ==========================================================
  // fault input synchronisers
  logic [2:0] meta_q;
  logic [2:0] sync_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      meta_q <= {fault_input, cmp2_out, cmp1_out};
      sync_q <= meta_q;
    end
  end

  // ==========================================================
  // shutdown cause
  wire enhanced = (cfg_act_q != pwm_shutdown_pkg::CFG_SINGLE);
  wire half = (cfg_act_q == pwm_shutdown_pkg::CFG_HALF);
  wire fwd = (cfg_act_q == pwm_shutdown_pkg::CFG_FULL_FWD);
  wire rev = (cfg_act_q == pwm_shutdown_pkg::CFG_FULL_REV);
  wire full = fwd || rev;

  // bit 0 comparator one, bit 1 comparator two, bit 2 fault pin
  wire [2:0] raw_in = {fault_input, cmp2_out, cmp1_out};
  wire cause_raw = enhanced && (|(src_q & raw_in));
  wire cause_sync = enhanced && (|(src_q & sync_q));

  // ==========================================================
  // status flag: a live cause beats any write or auto clear
  wire wr_flag = reg_wdata[pwm_shutdown_pkg::SD_FLAG_BIT];
  wire auto_val = restart_en_q ? 1'b0 : flag_q;
  wire sw_val = wr_sd ? wr_flag : auto_val;
  assign flag_d = cause_sync ? 1'b1 : sw_val;

  // hold keeps shutdown until a period starts with the flag clear
  wire flag_now = flag_q || cause_sync;
  assign hold_d = period_start ? flag_now
    : (hold_q || flag_now);

  // raw cause bypasses all flops so the pins drop with no clock
  wire forced = enhanced && (cause_raw || flag_q || hold_q);

  // ==========================================================
  // control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= pwm_shutdown_pkg::SHUTDOWN_RST[
        pwm_shutdown_pkg::SD_FLAG_BIT];
      src_q <= pwm_shutdown_pkg::SHUTDOWN_RST[6:4];
      ac_state_q <= pwm_shutdown_pkg::SHUTDOWN_RST[3:2];
      bd_state_q <= pwm_shutdown_pkg::SHUTDOWN_RST[1:0];
      restart_en_q <= pwm_shutdown_pkg::RESTART_RST[
        pwm_shutdown_pkg::RS_EN_BIT];
      db_count_q <= pwm_shutdown_pkg::RESTART_RST[DB_W-1:0];
      hold_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      hold_q <= hold_d;
      if (wr_sd) begin
        src_q <= reg_wdata[pwm_shutdown_pkg::SD_SRC_LSB +: 3];
        ac_state_q <= reg_wdata[pwm_shutdown_pkg::SD_AC_LSB +: 2];
        bd_state_q <= reg_wdata[pwm_shutdown_pkg::SD_BD_LSB +: 2];
      end
      if (wr_rs) begin
        restart_en_q <= reg_wdata[pwm_shutdown_pkg::RS_EN_BIT];
        db_count_q <= reg_wdata[DB_W-1:0];
      end
    end
  end

  // configuration written any time, taken on at a period start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= pwm_shutdown_pkg::CFG_SINGLE;
      cfg_act_q <= pwm_shutdown_pkg::CFG_SINGLE;
      pol_ac_q <= pwm_shutdown_pkg::PWM_CTRL_RST[1];
      pol_bd_q <= pwm_shutdown_pkg::PWM_CTRL_RST[0];
    end else begin
      if (wr_pc) begin
        cfg_q <= pwm_shutdown_pkg::out_cfg_t'(
          reg_wdata[pwm_shutdown_pkg::PC_CFG_LSB +: 2]);
        pol_ac_q <= reg_wdata[pwm_shutdown_pkg::PC_POL_AC_BIT];
        pol_bd_q <= reg_wdata[pwm_shutdown_pkg::PC_POL_BD_BIT];
      end
      if (period_start) begin
        cfg_act_q <= cfg_q;
      end
    end
  end

  // ==========================================================
  // dead-band stages, one per phase
  deadband_if #(.W(DB_W)) db_a ();
  deadband_if #(.W(DB_W)) db_b ();

  // full bridge gets no dead band; the modulated phase uses stage a
  wire [DB_W-1:0] db_eff = half ? db_count_q : '0;
  assign db_a.raw = pwm_raw;
  assign db_a.count = db_eff;
  assign db_b.raw = ~pwm_raw;
  assign db_b.count = db_eff;

  deadband_delay #(.W(DB_W)) u_db_a (
    .clk(clk),
    .reset_n(reset_n),
    .link(db_a.delay)
  );

  deadband_delay #(.W(DB_W)) u_db_b (
    .clk(clk),
    .reset_n(reset_n),
    .link(db_b.delay)
  );

  // ==========================================================
  // output steering, active level before polarity
  wire ph_a = db_a.shaped;
  wire ph_b = db_b.shaped;
  wire act_a = fwd ? 1'b1 : (rev ? 1'b0 : ph_a);
  wire act_b = half ? ph_b : (rev ? ph_a : 1'b0);
  wire act_c = rev;
  wire act_d = fwd ? ph_a : 1'b0;

  wire used_b = half || full;
  wire used_cd = full;

  // ==========================================================
  // pin drive: shutdown state overrides the active level
  wire ac_tri = ac_state_q[pwm_shutdown_pkg::PSS_TRI_BIT];
  wire ac_lvl = ac_state_q[pwm_shutdown_pkg::PSS_LEVEL_BIT];
  wire bd_tri = bd_state_q[pwm_shutdown_pkg::PSS_TRI_BIT];
  wire bd_lvl = bd_state_q[pwm_shutdown_pkg::PSS_LEVEL_BIT];

  assign out_a = forced ? ac_lvl : (act_a ^ pol_ac_q);
  assign out_a_oe = !(forced && ac_tri);
  assign out_c = forced ? ac_lvl : (act_c ^ pol_ac_q);
  assign out_c_oe = used_cd && !(forced && ac_tri);
  assign out_b = forced ? bd_lvl : (act_b ^ pol_bd_q);
  assign out_b_oe = used_b && !(forced && bd_tri);
  assign out_d = forced ? bd_lvl : (act_d ^ pol_bd_q);
  assign out_d_oe = used_cd && !(forced && bd_tri);

  // ==========================================================
  // read port: data only in the cycle after the strobe
  wire [7:0] rd_sd = {flag_q, src_q, ac_state_q, bd_state_q};
  wire [7:0] rd_rs = {restart_en_q, (7)'(db_count_q)};
  wire [7:0] rd_pc = {cfg_q, 4'h0, pol_ac_q, pol_bd_q};
  wire [7:0] rd_st = {6'h00, cause_sync, forced};
  wire [7:0] rd_lo = reg_addr[0] ? rd_rs : rd_sd;
  wire [7:0] rd_hi = reg_addr[0] ? rd_st : rd_pc;
  wire [7:0] rd_word = reg_addr[1] ? rd_hi : rd_lo;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= pwm_shutdown_pkg::RDATA_IDLE;
    end else begin
      rdata_q <= reg_rd ? rd_word : pwm_shutdown_pkg::RDATA_IDLE;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : pwm_auto_shutdown

`default_nettype wire

// file: testbench/pwm_auto_shutdown_properties.sv
// port checker for the pwm auto-shutdown block
// assumes registers change only through the register port
`timescale 1ns/1ps
`default_nettype none
module pwm_auto_shutdown_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic period_start,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic fault_input,
  input wire logic out_a,
  input wire logic out_a_oe,
  input wire logic out_b,
  input wire logic out_b_oe,
  input wire logic out_c_oe,
  input wire logic out_d_oe
);
  // ========
  // register mirrors
  logic [6:0] sd_q;
  logic [7:0] rs_q;
  logic [7:0] pc_q;
  logic [1:0] cfg_q;
  logic cause;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sd_q <= 7'h00;
      rs_q <= 8'h00;
      pc_q <= 8'h00;
      cfg_q <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == 2'h0) sd_q <= reg_wdata[6:0];
      if (reg_wr && reg_addr == 2'h1) rs_q <= reg_wdata;
      if (reg_wr && reg_addr == 2'h2) pc_q <= reg_wdata;
      if (period_start) cfg_q <= pc_q[7:6];
    end
  end
  // raw cause only; the synchronised flag is hidden from here
  assign cause = cfg_q != 2'h0 &&
    |(sd_q[6:4] & {fault_input, cmp2_out, cmp1_out});
  // ========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_single_idle: assert property (cfg_q == 2'h0 |->
    !out_b_oe && !out_c_oe && !out_d_oe)
    else $error("spare pins driven in single mode");
  a_ac_level: assert property (cause && !sd_q[3] |->
    out_a == sd_q[2] && out_a_oe) else $error("a/c shutdown level wrong");
  a_ac_release: assert property (cause && sd_q[3] |->
    !out_a_oe && !out_c_oe) else $error("a/c pair still driven");
  a_bd_level: assert property (cause && !sd_q[1] |->
    out_b == sd_q[0] && out_b_oe) else $error("b/d shutdown level wrong");
  a_bd_release: assert property (cause && sd_q[1] |->
    !out_b_oe && !out_d_oe) else $error("b/d pair still driven");
  a_flag_sets: assert property (cause [*5] ##0
    (reg_rd && reg_addr == 2'h0) |=> reg_rdata[7])
    else $error("status flag clear under a cause");
  a_restart_readback: assert property (reg_rd && reg_addr == 2'h1
    |=> reg_rdata == rs_q) else $error("restart register readback");
  a_source_readback: assert property (reg_rd && reg_addr == 2'h0
    |=> reg_rdata[6:0] == sd_q) else $error("shutdown fields readback");
endmodule : pwm_auto_shutdown_properties

bind pwm_auto_shutdown pwm_auto_shutdown_properties u_props (.clk,
  .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .period_start, .cmp1_out, .cmp2_out, .fault_input, .out_a, .out_a_oe,
  .out_b, .out_b_oe, .out_c_oe, .out_d_oe);
`default_nettype wire

// file: testbench/bridge_model.sv
// far side: period timer, duty generator, comparators and fault pin
// assumes the block's clock; trip levels come from the bench
`timescale 1ns/1ps
`default_nettype none
module bridge_model #(
  parameter int PER = 32,
  parameter int DUTY = 24
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] trip,
  output logic pwm_raw,
  output logic period_start,
  output logic cmp1_out,
  output logic cmp2_out,
  output logic fault_input
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cnt_q <= 8'h00;
    else cnt_q <= (cnt_q == 8'(PER - 1)) ? 8'h00 : cnt_q + 8'h01;
  end
  // one pulse per timer match
  assign period_start = reset_n && cnt_q == 8'h00;
  assign pwm_raw = cnt_q < 8'(DUTY);
  // levels, not pulses: a comparator holds while tripped
  assign {fault_input, cmp2_out, cmp1_out} = trip;
endmodule : bridge_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the pwm auto-shutdown block
// assumes the bridge model supplies pwm, period start and trips
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] trip = 3'h0;
  logic [7:0] reg_rdata;
  logic pwm_raw, period_start, cmp1_out, cmp2_out, fault_input;
  logic out_a, out_a_oe, out_b, out_b_oe, out_c, out_c_oe, out_d, out_d_oe;
  logic [7:0] pins;
  logic [7:0] exp_q[$];
  logic [3:0] fld;
  logic [3:0] oe_tab [4] = '{4'h8, 4'hf, 4'hc, 4'hf};
  logic rd_q = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 78;
  int n0;
  int n1;
  assign pins = {2'h0, out_a, out_a_oe, out_b, out_b_oe, out_c_oe, out_d_oe};
  always #10 clk = ~clk;
  pwm_auto_shutdown u_pwm_auto_shutdown (.clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pwm_raw, .period_start,
    .cmp1_out, .cmp2_out, .fault_input, .out_a, .out_a_oe, .out_b,
    .out_b_oe, .out_c, .out_c_oe, .out_d, .out_d_oe);
  bridge_model u_bridge_model (.clk, .reset_n, .trip, .pwm_raw,
    .period_start, .cmp1_out, .cmp2_out, .fault_input);
  // ========
  // bus and compare helpers
  task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic sync();
    do @(posedge clk); while (period_start !== 1'b1);
  endtask : sync
  task automatic rise_gap(output int n);
    sync();
    n = 0;
    while (out_a !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
      check("overlap", 8'(out_a & out_b), 8'h00);
    end
  endtask : rise_gap
  always @(posedge clk) begin
    rd_q <= reg_rd;
    if (rd_q) check("reg_rdata", reg_rdata, exp_q.pop_front());
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // ========
  // scenarios
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 3; i++) rd(2'(i), 8'h00);
    for (int i = 0; i < 4; i++) begin
      n0 = $random(seed);
      wr(2'h1, n0[7:0]);
      rd(2'h1, n0[7:0]);
    end
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h80);
    sync();
    sync();
    for (int s = 0; s < 8; s++) begin
      fld = s[0] ? 4'h1 : 4'he;
      sync();
      wr(2'h0, {1'b0, 3'(s), fld});
      trip <= 3'(s & -s) | ~3'(s);
      #1 if (s != 0) check("pins", pins & (s[0] ? 8'hff : 8'h17),
        s[0] ? 8'h1c : 8'h00);
      repeat (6) @(posedge clk);
      wr(2'h0, {1'b0, 3'(s), fld});
      rd(2'h0, {s != 0, 3'(s), fld});
      trip <= 3'h0;
      repeat (4) @(posedge clk);
      rd(2'h0, {s != 0, 3'(s), fld});
      wr(2'h0, {1'b0, 3'(s), fld});
      rd(2'h0, {1'b0, 3'(s), fld});
    end
    wr(2'h1, 8'h80);
    sync();
    trip <= 3'h4;
    repeat (5) @(posedge clk);
    trip <= 3'h0;
    repeat (7) @(posedge clk);
    rd(2'h0, 8'h71);
    check("pins", pins, 8'h1c);
    sync();
    repeat (3) @(posedge clk);
    check("pins", pins, 8'h34);
    wr(2'h1, 8'h00);
    rise_gap(n0);
    wr(2'h1, 8'h05);
    rise_gap(n1);
    check("gap", 8'(n1 - n0), 8'h05);
    wr(2'h2, 8'h82);
    sync();
    sync();
    repeat (10) @(posedge clk);
    check("pins", pins, 8'h14);
    wr(2'h0, 8'h9c);
    check("oe", 8'({out_a_oe, out_b, out_b_oe}), 8'h01);
    wr(2'h0, 8'h1c);
    rd(2'h0, 8'h1c);
    for (int c = 0; c < 4; c++) begin
      wr(2'h2, {2'(c), 6'h00});
      sync();
      sync();
      repeat (2) @(posedge clk);
      check("oe", 8'({out_a_oe, out_b_oe, out_c_oe, out_d_oe}),
        8'(oe_tab[c]));
      // full bridge: c steady in reverse, d modulated in forward
      check("cd", 8'({out_c, out_d}), 8'({c == 3, c == 1}));
    end
    end_of_test();
  end
  // a hang costs one mismatch; the run needs about 800 cycles
  initial begin
    #200us;
    num_errors++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
